/* logic/sbc_regs.svh */
`ifndef SBC_REGS_SVH
`define SBC_REGS_SVH
// bank address codes that pick the mode register on a set command
`define SBC_BA_MR0 3'h0
`define SBC_BA_MR1 3'h1
// field positions inside the burst configuration register
`define SBC_BL_LO 0
`define SBC_BL_HI 1
`define SBC_CL_LOW 2
`define SBC_BT_BIT 3
`define SBC_CL_LO 4
`define SBC_CL_HI 6
`define SBC_TM_BIT 7
`define SBC_DLLRST_BIT 8
`define SBC_WR_LO 9
`define SBC_WR_HI 11
`define SBC_PPD_BIT 12
// command address bits: chop sampled with read and write, auto precharge with write only
`define SBC_AP_BIT 10
`define SBC_CHOP_BIT 12
// register width kept and its reset value
`define SBC_CFG_W 13
`define SBC_CFG_RST 13'h0000
// timing
`define SBC_TCK_NS 100
`define SBC_TRP_NS 15
`define SBC_TRP_CYC ((`SBC_TRP_NS + `SBC_TCK_NS - 1) / `SBC_TCK_NS)
`define SBC_TDLLK_CYC 512
`define SBC_WREF_CYC 8
`define SBC_CHOP_PULL_CYC 2
`endif

/* logic/sbc_pkg.sv */
package sbc_pkg;
  // burst length field encodings
  typedef enum logic [1:0] {
    SBC_BL_EIGHT = 2'b00,
    SBC_BL_OTF = 2'b01,
    SBC_BL_CHOP = 2'b10,
    SBC_BL_RSVD = 2'b11
  } sbc_burst_len_t;
  // read engine states
  typedef enum logic [1:0] {
    SBC_RD_IDLE = 2'b00,
    SBC_RD_WAIT = 2'b01,
    SBC_RD_BURST = 2'b10
  } sbc_rd_state_t;
endpackage

/* logic/sbc_stream_if.sv */
`timescale 1ns/1ps
interface sbc_stream_if #(parameter int W = 16);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* logic/sbc_fifo.sv */
`timescale 1ns/1ps
module sbc_fifo #(
  parameter int W = 16,
  parameter int D = 4
) (
  input wire logic clk_in, // clock
  input wire logic nrst_in, // async reset, active low
  sbc_stream_if.snk fill, // filling side
  sbc_stream_if.src drain // draining side
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic room;
  wire push = fill.valid && room;
  wire pop = drain.ready && (count != '0);
  wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // room comes straight from a flop so ready never depends on the drain this cycle
  assign fill.ready = room;
  assign drain.valid = (count != '0);
  assign drain.data = mem[rd_ptr];

  // pointer wrap assumes a power of two depth
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      room <= 1'b1;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      count <= next_count;
      room <= (next_count != D[AW:0]);
    end
  end

  // storage needs no reset
  always_ff @(posedge clk_in) begin
    if (push) mem[wr_ptr] <= fill.data;
  end
endmodule

/* logic/sbc_burst_ctrl.sv */
// Behaviour
// R1 - A3 picks burst type: 0 sequential nibble order, 1 interleaved order.
// R2 - A1:A0 pick burst length: fixed chop, fixed eight, or on the fly.
// R3 - on the fly, A12 with each read or write picks chop or eight.
// R4 - sequential eight read wraps low two bits in nibble, then other nibble.
// R5 - interleaved eight read takes column beat index xor start column.
// R6 - chopped read sends first four of eight order, then drivers off.
// R7 - chopped write uses only start bit 2, ascending, last four beats ignored.
// R8 - eight beat write ignores start bits, writes columns 0 to 7 ascending.
// R9 - fixed chop starts internal write two clocks earlier than eight.
// R10 - on the fly chop starts internal write at the eight beat point.
// R11 - cas delay is whole clocks from internal read to first data.
// R12 - read delay is added delay plus cas delay from read command.
// R13 - controller keeps A7 at zero; one enters an unguaranteed test mode.
// R14 - dll reset bit returns to zero by itself after the reset.
// R15 - controller waits tDLLK after dll reset before reads or odt.
// R16 - controller should reset the dll after enabling it.
// R17 - write recovery plus tRP forms the auto precharge interval.
// R18 - controller programs write recovery at least ceil of tWR over tCK.
// R19 - A12 zero freezes dll in precharge power down, slow exit.
// R20 - A12 one keeps dll running in precharge power down, fast exit.
// R21 - second mode register write: command pins low, BA0 high, BA1 BA2 low.
// R22 - burst config write: command pins and all bank bits low.
// R23 - controller drives BA2 and A13 to A15 zero on mode set.
// R24 - mode registers rewritten only when the device is idle.
// R25 - chopped read from column 5 follows the same order rule.
`timescale 1ns/1ps
`include "sbc_regs.svh"
module sbc_burst_ctrl #(
  parameter int DW = 16,
  parameter int FIFO_DEPTH = 4,
  parameter int TDLLK_CYC = `SBC_TDLLK_CYC
) (
  input wire logic ref_clk_in, // system clock
  input wire logic nrst_in, // async reset, active low
  input wire logic cs_n_in, // chip select, active low
  input wire logic ras_n_in, // row strobe, active low
  input wire logic cas_n_in, // column strobe, active low
  input wire logic we_n_in, // write enable, active low
  input wire logic [2:0] ba_in, // bank address
  input wire logic [15:0] addr_in, // address pins
  input wire logic cke_in, // clock enable, low is power down
  input wire logic [4:0] added_delay_in, // added delay in clocks
  input wire logic wdata_valid_in, // write beat present
  input wire logic [DW-1:0] dq_in, // write beat data
  output logic wdata_ready_out, // write beat can be taken
  output logic [DW-1:0] dq_out, // read data
  output logic dq_oe_out, // read data driven
  output logic dqs_out, // read strobe level
  output logic dqs_oe_out, // read strobe driven
  output logic [`SBC_CFG_W-1:0] burst_config_out, // register contents
  output logic [4:0] cas_delay_out, // decoded cas delay
  output logic [5:0] read_delay_out, // added plus cas delay
  output logic [4:0] write_recovery_out, // decoded write recovery
  output logic test_mode_out, // test mode bit set
  output logic dll_locked_out, // dll settled after reset
  output logic dll_frozen_out, // dll held in power down
  output logic wr_ref_out, // internal write reference pulse
  output logic precharge_done_out, // auto precharge done pulse
  output logic mr1_write_out // second mode register write pulse
);
  sbc_pkg::sbc_rd_state_t rd_state;
  sbc_pkg::sbc_rd_state_t next_rd_state;
  logic [DW-1:0] mem [8];
  logic [`SBC_CFG_W-1:0] cfg;
  logic dll_rst_pend;
  logic [$clog2(TDLLK_CYC+1)-1:0] dll_cnt;
  logic [5:0] rd_cnt;
  logic [2:0] rd_beat;
  logic [2:0] rd_start;
  logic rd_chop;
  logic rd_il;
  logic [3:0] wr_left;
  logic [2:0] wr_idx;
  logic wr_base;
  logic wr_chop;
  logic [3:0] wref_cnt;
  logic wref_ap;
  logic [5:0] dal_cnt;

  // column of a beat inside the burst
  function automatic logic [2:0] col_of(input logic [2:0] start, input logic [2:0] i,
                                        input logic il);
    logic [1:0] lo;
    lo = start[1:0] + i[1:0];
    if (il) begin
      col_of = start ^ i; // see R5
    end else begin
      col_of = {start[2] ^ i[2], lo}; // see R4
    end
  endfunction

  // cas delay field to clocks, zero when reserved
  function automatic logic [4:0] cl_of(input logic [3:0] f);
    if (f[0]) begin
      cl_of = (f[3:1] <= 3'h2) ? 5'(12 + f[3:1]) : 5'h00;
    end else begin
      cl_of = (f[3:1] == 3'h0) ? 5'h00 : 5'(4 + f[3:1]);
    end
  endfunction

  // write recovery field to clocks, zero when reserved
  function automatic logic [4:0] wr_of(input logic [2:0] f);
    case (f)
      3'h1: wr_of = 5'h05;
      3'h2: wr_of = 5'h06;
      3'h3: wr_of = 5'h07;
      3'h4: wr_of = 5'h08;
      3'h5: wr_of = 5'h0A;
      3'h6: wr_of = 5'h0C;
      3'h7: wr_of = 5'h0E;
      default: wr_of = 5'h00;
    endcase
  endfunction

  // command decode; reserved high bits are simply not stored
  wire cmd_mrs = !cs_n_in && !ras_n_in && !cas_n_in && !we_n_in;
  wire cmd_mr0 = cmd_mrs && (ba_in == `SBC_BA_MR0); // see R22
  wire cmd_mr1 = cmd_mrs && (ba_in == `SBC_BA_MR1); // see R21
  wire cmd_col = !cs_n_in && ras_n_in && !cas_n_in;
  wire cmd_rd = cmd_col && we_n_in;
  wire cmd_wr = cmd_col && !we_n_in;

  // current settings
  wire [1:0] bl_field = cfg[`SBC_BL_HI:`SBC_BL_LO];
  wire bl_otf = (bl_field == sbc_pkg::SBC_BL_OTF);
  wire bl_fixed_chop = (bl_field == sbc_pkg::SBC_BL_CHOP);
  wire cmd_chop = bl_fixed_chop || (bl_otf && !addr_in[`SBC_CHOP_BIT]); // see R2, R3
  wire interleave = cfg[`SBC_BT_BIT]; // see R1
  wire [4:0] cl_now = cl_of({cfg[`SBC_CL_HI:`SBC_CL_LO], cfg[`SBC_CL_LOW]}); // see R11
  wire [5:0] rl_now = {1'b0, added_delay_in} + {1'b0, cl_now}; // see R12
  wire [4:0] wr_now = wr_of(cfg[`SBC_WR_HI:`SBC_WR_LO]);
  wire power_down = !cke_in;

  // write beat path through the fifo
  sbc_stream_if #(.W(DW)) fill_if ();
  sbc_stream_if #(.W(DW)) drain_if ();
  assign fill_if.valid = wdata_valid_in;
  assign fill_if.data = dq_in;
  assign wdata_ready_out = fill_if.ready;
  // drain stalls while the read engine is not idle, waiting or bursting
  assign drain_if.ready = (wr_left != 4'h0) && (rd_state == sbc_pkg::SBC_RD_IDLE);
  wire beat_pop = drain_if.ready && drain_if.valid;
  wire beat_keep = !wr_chop || !wr_idx[2]; // see R7
  wire [2:0] beat_col = {wr_base | wr_idx[2], wr_idx[1:0]}; // see R7, R8

  sbc_fifo #(.W(DW), .D(FIFO_DEPTH)) u_wfifo (
    .clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .fill(fill_if),
    .drain(drain_if)
  );

  // read engine next state and next beat
  wire rd_wait_done = (rd_state == sbc_pkg::SBC_RD_WAIT) && (rd_cnt == 6'h00);
  wire [2:0] out_idx = rd_wait_done ? 3'h0 : rd_beat + 3'h1;
  wire out_drive = !rd_chop || !out_idx[2]; // see R6, R25
  wire [2:0] out_col = col_of(rd_start, out_idx, rd_il);
  always_comb begin
    next_rd_state = rd_state;
    case (rd_state)
      sbc_pkg::SBC_RD_IDLE: if (cmd_rd) next_rd_state = sbc_pkg::SBC_RD_WAIT;
      sbc_pkg::SBC_RD_WAIT: if (rd_cnt == 6'h00) next_rd_state = sbc_pkg::SBC_RD_BURST;
      sbc_pkg::SBC_RD_BURST: if (rd_beat == 3'h7) next_rd_state = sbc_pkg::SBC_RD_IDLE;
      default: next_rd_state = sbc_pkg::SBC_RD_IDLE;
    endcase
  end

  // read state and counters; a read during a read is not accepted
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_state <= sbc_pkg::SBC_RD_IDLE;
      rd_cnt <= 6'h00;
      rd_beat <= 3'h0;
      rd_start <= 3'h0;
      rd_chop <= 1'b0;
      rd_il <= 1'b0;
    end else begin
      rd_state <= next_rd_state;
      if (rd_state == sbc_pkg::SBC_RD_IDLE && cmd_rd) begin
        rd_cnt <= (rl_now != 6'h00) ? rl_now - 6'h01 : 6'h00; // see R12
        rd_start <= addr_in[2:0];
        rd_chop <= cmd_chop; // see R3
        rd_il <= interleave;
      end else if (rd_state == sbc_pkg::SBC_RD_WAIT) begin
        rd_cnt <= rd_cnt - 6'h01;
        rd_beat <= 3'h0;
      end else if (rd_state == sbc_pkg::SBC_RD_BURST) begin
        rd_beat <= rd_beat + 3'h1;
      end
    end
  end

  // read pins, all registered
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dq_out <= '0;
      dq_oe_out <= 1'b0;
      dqs_out <= 1'b0;
      dqs_oe_out <= 1'b0;
    end else if (rd_wait_done || (rd_state == sbc_pkg::SBC_RD_BURST && rd_beat != 3'h7)) begin
      dq_out <= mem[out_col]; // see R4, R5
      dq_oe_out <= out_drive; // see R6
      dqs_out <= out_idx[0];
      dqs_oe_out <= out_drive; // see R6
    end else begin
      dq_oe_out <= 1'b0;
      dqs_oe_out <= 1'b0;
      dqs_out <= 1'b0;
    end
  end

  // configuration register and dll reset; a new write beats the self clear
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg <= `SBC_CFG_RST;
      dll_rst_pend <= 1'b0;
    end else if (cmd_mr0) begin
      cfg <= addr_in[`SBC_CFG_W-1:0];
      dll_rst_pend <= addr_in[`SBC_DLLRST_BIT];
    end else if (dll_rst_pend) begin
      cfg[`SBC_DLLRST_BIT] <= 1'b0; // see R14
      dll_rst_pend <= 1'b0;
    end
  end

  // dll settling count; frozen in slow exit power down
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dll_cnt <= '0;
      dll_locked_out <= 1'b1;
      dll_frozen_out <= 1'b0;
    end else begin
      dll_frozen_out <= power_down && !cfg[`SBC_PPD_BIT]; // see R19, R20
      if (dll_rst_pend) begin
        dll_cnt <= ($bits(dll_cnt))'(TDLLK_CYC);
        dll_locked_out <= 1'b0;
      end else if (dll_cnt != '0 && !dll_frozen_out) begin
        dll_cnt <= dll_cnt - 1'b1;
        dll_locked_out <= (dll_cnt == 1); // see R15
      end
    end
  end

  // write burst bookkeeping: beats left, beat index, start column and chop
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_left <= 4'h0;
      wr_idx <= 3'h0;
      wr_base <= 1'b0;
      wr_chop <= 1'b0;
    end else if (cmd_wr && (wr_left == 4'h0 || (beat_pop && wr_left == 4'h1))) begin
      wr_left <= 4'h8;
      wr_idx <= 3'h0;
      wr_base <= cmd_chop && addr_in[2]; // see R7, R8
      wr_chop <= cmd_chop;
    end else if (beat_pop) begin
      wr_left <= wr_left - 4'h1;
      wr_idx <= wr_idx + 3'h1;
    end
  end

  // column array, written only for beats that land
  always_ff @(posedge ref_clk_in) begin
    if (beat_pop && beat_keep) mem[beat_col] <= drain_if.data;
  end

  // internal write point and auto precharge interval
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wref_cnt <= 4'h0;
      wref_ap <= 1'b0;
      dal_cnt <= 6'h00;
      wr_ref_out <= 1'b0;
      precharge_done_out <= 1'b0;
    end else begin
      wr_ref_out <= (wref_cnt == 4'h1);
      precharge_done_out <= (dal_cnt == 6'h01);
      if (cmd_wr) begin
        // fixed chop pulls the point in; on the fly chop does not
        wref_cnt <= bl_fixed_chop ? 4'(`SBC_WREF_CYC - `SBC_CHOP_PULL_CYC)
                                  : 4'(`SBC_WREF_CYC); // see R9, R10
        wref_ap <= addr_in[`SBC_AP_BIT];
      end else if (wref_cnt != 4'h0) begin
        wref_cnt <= wref_cnt - 4'h1;
      end
      if (wref_cnt == 4'h1 && wref_ap) begin
        dal_cnt <= {1'b0, wr_now} + 6'(`SBC_TRP_CYC); // see R17
      end else if (dal_cnt != 6'h00) begin
        dal_cnt <= dal_cnt - 6'h01;
      end
    end
  end

  // status outputs
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      burst_config_out <= `SBC_CFG_RST;
      cas_delay_out <= 5'h00;
      read_delay_out <= 6'h00;
      write_recovery_out <= 5'h00;
      test_mode_out <= 1'b0;
      mr1_write_out <= 1'b0;
    end else begin
      burst_config_out <= cfg;
      cas_delay_out <= cl_now;
      read_delay_out <= rl_now;
      write_recovery_out <= wr_now;
      test_mode_out <= cfg[`SBC_TM_BIT]; // see R13
      mr1_write_out <= cmd_mr1;
    end
  end
endmodule

/* dv/sbc_ctrl_model.sv */
`timescale 1ns/1ps
module sbc_ctrl_model (
  input wire logic clk_in, // clock
  input wire logic dll_locked_in, // device dll settled
  input wire logic wready_in, // write beat taken
  output logic cs_n_out, // chip select
  output logic ras_n_out, // row strobe
  output logic cas_n_out, // column strobe
  output logic we_n_out, // write enable
  output logic [2:0] ba_out, // bank address
  output logic [15:0] addr_out, // address pins
  output logic cke_out, // clock enable
  output logic wvalid_out, // write beat present
  output logic [15:0] wdata_out // write beat data
);
  // idle bus at time zero
  initial begin
    {cs_n_out, ras_n_out, cas_n_out, we_n_out, cke_out} = 5'h1f;
    {ba_out, addr_out, wvalid_out, wdata_out} = '0;
  end
  // one command, op is {ras,cas,we}; reads hold off until the dll has settled
  task automatic issue(input logic [2:0] op, input logic [2:0] b, input logic [15:0] a);
    if (op == 3'b101) while (dll_locked_in !== 1'b1) @(posedge clk_in);
    @(posedge clk_in);
    {ras_n_out, cas_n_out, we_n_out} <= op;
    cs_n_out <= 1'b0;
    ba_out <= (op == 3'b000) ? {1'b0, b[1:0]} : b;
    addr_out <= (op == 3'b000) ? {3'h0, a[12:8], 1'b0, a[6:0]} : a;
    @(posedge clk_in);
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= 4'hf;
    addr_out <= ~addr_out; // released lines do not keep the old value
    ba_out <= ~ba_out;
  endtask
  // eight write beats, each held until taken
  task automatic push8(input logic [7:0][15:0] d);
    for (int i = 0; i < 8; i++) begin
      wdata_out <= d[i];
      wvalid_out <= 1'b1;
      @(posedge clk_in);
      while (wready_in !== 1'b1) @(posedge clk_in);
    end
    wvalid_out <= 1'b0;
    wdata_out <= ~wdata_out;
  endtask
  // short precharge power down
  task automatic pd();
    @(posedge clk_in);
    cke_out <= 1'b0;
    repeat (3) @(posedge clk_in);
    cke_out <= 1'b1;
  endtask
endmodule

/* dv/sbc_burst_ctrl_sva.sv */
`timescale 1ns/1ps
`include "sbc_regs.svh"
module sbc_burst_ctrl_sva #(
  parameter int TDLLK_CYC = `SBC_TDLLK_CYC
) (
  input wire logic ref_clk_in, // clock
  input wire logic nrst_in, // reset, active low
  input wire logic cs_n_in, // chip select
  input wire logic ras_n_in, // row strobe
  input wire logic cas_n_in, // column strobe
  input wire logic we_n_in, // write enable
  input wire logic [2:0] ba_in, // bank address
  input wire logic [15:0] addr_in, // address pins
  input wire logic cke_in, // clock enable
  input wire logic [4:0] added_delay_in, // added delay
  input wire logic dq_oe_out, // data driven
  input wire logic dqs_out, // strobe level
  input wire logic dqs_oe_out, // strobe driven
  input wire logic [`SBC_CFG_W-1:0] burst_config_out, // register
  input wire logic [4:0] cas_delay_out, // cas delay
  input wire logic [5:0] read_delay_out, // read delay
  input wire logic [4:0] write_recovery_out, // write recovery
  input wire logic dll_locked_out, // dll settled
  input wire logic dll_frozen_out, // dll held
  input wire logic wr_ref_out, // write reference
  input wire logic precharge_done_out, // precharge done
  input wire logic test_mode_out, // test mode bit
  input wire logic mr1_write_out // second register write pulse
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  // command decode from the pins
  wire cmd = !cs_n_in && !cas_n_in;
  wire mrs0 = cmd && !ras_n_in && !we_n_in && ba_in == 3'h0;
  wire mrs1 = cmd && !ras_n_in && !we_n_in && ba_in == 3'h1;
  wire rd = cmd && ras_n_in && we_n_in;
  wire wr = cmd && ras_n_in && !we_n_in;
  wire [1:0] bl = burst_config_out[`SBC_BL_HI:`SBC_BL_LO];
  wire chop_now = bl == sbc_pkg::SBC_BL_CHOP || (bl == sbc_pkg::SBC_BL_OTF && !addr_in[12]);
  logic chop_rd;
  logic [9:0] lock_cnt;
  logic [5:0] since_ref;
  // chop of the last read, relock wait (paused while frozen), age of write point
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      chop_rd <= 1'b0;
      lock_cnt <= '0;
      since_ref <= '0;
    end else begin
      if (rd) chop_rd <= chop_now;
      lock_cnt <= dll_locked_out ? '0 : (dll_frozen_out ? lock_cnt : lock_cnt + 10'h001);
      since_ref <= wr_ref_out ? 6'h01 : (since_ref == 6'h3f ? since_ref : since_ref + 6'h01);
    end
  end
  // reserved cas codes read back as zero
  function automatic logic [4:0] cl_of(input logic [15:0] a);
    if (a[2]) return (a[6:4] > 3'h2) ? 5'h00 : {2'h0, a[6:4]} + 5'h0c;
    return (a[6:4] == 3'h0) ? 5'h00 : {2'h0, a[6:4]} + 5'h04;
  endfunction
  function automatic logic [4:0] wr_of(input logic [2:0] c);
    return (c > 3'h4) ? {1'b0, c, 1'b0} : (c == 3'h0 ? 5'h00 : {2'h0, c} + 5'h04);
  endfunction
  chk_cfg_store: assert property (mrs0 |-> ##2
    burst_config_out[7:0] == $past(addr_in[7:0], 2) &&
    burst_config_out[12:9] == $past(addr_in[12:9], 2))
    else $error("config register contents wrong");
  chk_cas_decode: assert property (mrs0 |-> ##3
    cas_delay_out == cl_of($past(addr_in, 3)))
    else $error("cas delay decode wrong");
  chk_rd_delay: assert property (mrs0 |-> ##3
    read_delay_out == {1'b0, cas_delay_out} + {1'b0, added_delay_in})
    else $error("read delay sum wrong");
  chk_wr_decode: assert property (mrs0 |-> ##3
    write_recovery_out == wr_of($past(addr_in[11:9], 3)))
    else $error("write recovery decode wrong");
  // the register copy on the pins lags the self clear by one cycle
  chk_dll_clear: assert property (mrs0 && addr_in[8] |-> ##2
    !dll_locked_out ##1 !burst_config_out[8])
    else $error("dll reset bit not self cleared");
  chk_dll_relock: assert property (lock_cnt <= TDLLK_CYC + 1)
    else $error("dll relock too slow");
  chk_fix_chop: assert property (wr && bl == sbc_pkg::SBC_BL_CHOP |-> ##[7:8] wr_ref_out)
    else $error("fixed chop write point wrong");
  chk_eight_ref: assert property (wr && bl != sbc_pkg::SBC_BL_CHOP |->
    ##[9:10] wr_ref_out)
    else $error("eight beat write point wrong");
  chk_chop_read: assert property ($rose(dq_oe_out) && chop_rd |->
    dq_oe_out[*4] ##1 !dq_oe_out[*4])
    else $error("chopped read slots wrong");
  chk_eight_read: assert property ($rose(dq_oe_out) && !chop_rd |->
    dq_oe_out[*8] ##1 !dq_oe_out)
    else $error("eight beat read slots wrong");
  chk_strobe: assert property (dq_oe_out |-> dqs_oe_out &&
    ($past(dq_oe_out) ? dqs_out != $past(dqs_out) : !dqs_out))
    else $error("read strobe wrong");
  chk_pd_dll: assert property (1'b1 |=>
    dll_frozen_out == (!$past(cke_in) && !$past(burst_config_out[12])))
    else $error("power down dll state wrong");
  chk_ap_time: assert property (precharge_done_out |->
    since_ref == {1'b0, write_recovery_out} + 6'h01)
    else $error("auto precharge interval wrong");
  chk_mr1_pulse: assert property (mrs1 |=> mr1_write_out ##1 !mr1_write_out)
    else $error("second register write pulse wrong");
  chk_test_mode: assert property (test_mode_out == burst_config_out[7])
    else $error("test mode flag wrong");
  cov_chop_rd: cover property (rd && chop_now);
  cov_ap_wr: cover property (wr && addr_in[10]);
  cov_frozen: cover property (dll_frozen_out);
endmodule
bind sbc_burst_ctrl sbc_burst_ctrl_sva #(.TDLLK_CYC(TDLLK_CYC)) i_sbc_burst_ctrl_sva (
  .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .cs_n_in(cs_n_in), .ras_n_in(ras_n_in),
  .cas_n_in(cas_n_in), .we_n_in(we_n_in), .ba_in(ba_in), .addr_in(addr_in), .cke_in(cke_in),
  .added_delay_in(added_delay_in), .dq_oe_out(dq_oe_out), .dqs_out(dqs_out),
  .dqs_oe_out(dqs_oe_out), .burst_config_out(burst_config_out), .cas_delay_out(cas_delay_out),
  .read_delay_out(read_delay_out), .write_recovery_out(write_recovery_out),
  .dll_locked_out(dll_locked_out), .dll_frozen_out(dll_frozen_out), .wr_ref_out(wr_ref_out),
  .precharge_done_out(precharge_done_out), .test_mode_out(test_mode_out),
  .mr1_write_out(mr1_write_out));

/* dv/tb.sv */
`timescale 1ns/1ps
`include "sbc_regs.svh"
module tb;
  logic ref_clk_in, nrst_in, bt, cs_n, ras_n, cas_n, we_n, cke, wvalid, wready, dq_oe, dll_locked;
  logic [2:0] ba, code;
  logic [15:0] addr, wdata, dq, cfg;
  logic [4:0] al;
  logic tm, mr1;
  logic [12:0] bco;
  logic [1:0] blv;
  logic [31:0] rng;
  logic [15:0] mem [8];
  logic [15:0] exp_q [$];
  int fails, cmp_count;
  sbc_burst_ctrl #(.TDLLK_CYC(8)) i_sbc_burst_ctrl (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .cs_n_in(cs_n), .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .ba_in(ba),
    .addr_in(addr), .cke_in(cke), .added_delay_in(al), .wdata_valid_in(wvalid), .dq_in(wdata),
    .wdata_ready_out(wready), .dq_out(dq), .dq_oe_out(dq_oe), .dqs_out(), .dqs_oe_out(),
    .burst_config_out(bco), .cas_delay_out(), .read_delay_out(), .write_recovery_out(),
    .test_mode_out(tm), .dll_locked_out(dll_locked), .dll_frozen_out(), .wr_ref_out(),
    .precharge_done_out(), .mr1_write_out(mr1));
  sbc_ctrl_model i_sbc_ctrl_model (.clk_in(ref_clk_in), .dll_locked_in(dll_locked),
    .wready_in(wready), .cs_n_out(cs_n), .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n),
    .ba_out(ba), .addr_out(addr), .cke_out(cke), .wvalid_out(wvalid), .wdata_out(wdata));
  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", what, e, g);
      fails++;
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // every driven beat is matched against the oldest note
  always @(negedge ref_clk_in) begin
    if (dq_oe === 1'b1) begin
      chk("read beat", exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx, dq);
    end
  end
  // chop comes from the mode field, or from the pin when chosen per command
  function automatic logic is_chop(input logic a12);
    return blv == sbc_pkg::SBC_BL_CHOP || (blv == sbc_pkg::SBC_BL_OTF && !a12);
  endfunction
  task automatic do_mrs(input logic [15:0] a);
    i_sbc_ctrl_model.issue(3'b000, 3'h0, a);
    repeat (4) @(posedge ref_clk_in);
    chk("config", {3'h0, a[12:9], 1'b0, a[7:0]}, {3'h0, bco});
    chk("test mode", 16'h0000, {15'h0, tm});
  endtask
  task automatic do_read(input logic [2:0] s, input logic a12);
    int n;
    for (int i = 0; i < (is_chop(a12) ? 4 : 8); i++) begin
      exp_q.push_back(mem[bt ? s ^ 3'(i) : {s[2] ^ 1'(i >> 2), s[1:0] + 2'(i)}]);
    end
    i_sbc_ctrl_model.issue(3'b101, 3'h0, {3'h0, a12, 9'h000, s});
    n = 0;
    @(negedge ref_clk_in);
    while (dq_oe !== 1'b1 && n < 64) begin
      n++;
      @(negedge ref_clk_in);
    end
    chk("read delay", 16'(al) + 16'(code) + 16'h0004, 16'(n));
    repeat (12) @(posedge ref_clk_in);
  endtask
  // beats are queued first so the four deep buffer fills and refuses
  task automatic do_write(input logic [2:0] s, input logic a12, input logic ap);
    logic [7:0][15:0] d;
    for (int i = 0; i < 8; i++) begin
      rng = xs(rng);
      d[i] = rng[15:0];
    end
    for (int i = 0; i < (is_chop(a12) ? 4 : 8); i++) begin
      mem[is_chop(a12) ? {s[2], 2'(i)} : 3'(i)] = d[i];
    end
    fork
      i_sbc_ctrl_model.push8(d);
      begin
        repeat (7) @(posedge ref_clk_in);
        chk("buffer ready", 16'h0000, {15'h0, wready});
        i_sbc_ctrl_model.issue(3'b100, 3'h0, {3'h0, a12, 1'b0, ap, 7'h00, s});
      end
    join
    repeat (24) @(posedge ref_clk_in);
  endtask
  initial begin
    nrst_in = 1'b0;
    al = '0;
    code = 3'h1;
    rng = 32'h0000_74c8;
    repeat (8) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    @(posedge ref_clk_in);
    chk("dll locked", 16'h0001, {15'h0, dll_locked});
    // both burst types across eight, fixed chop and per command chop
    for (int t = 0; t < 6; t++) begin
      bt = (t >= 3);
      blv = (t % 3 == 0) ? 2'b00 : ((t % 3 == 1) ? 2'b10 : 2'b01);
      rng = xs(rng);
      code = 3'(rng[2:0] % 7) + 3'h1;
      al <= {2'h0, rng[5:3]};
      cfg = {3'h0, rng[8], 3'h1, 2'b00, code, bt, 1'b0, blv}; // write recovery 5 cycles
      do_mrs(cfg);
      i_sbc_ctrl_model.pd();
      do_write(rng[11:9], rng[12], t[0]);
      for (int s = 0; s < 8; s++) begin
        rng = xs(rng);
        do_read(3'(s), rng[0]);
      end
    end
    // dll reset after enabling, then a read that must wait for relock
    do_mrs(cfg | 16'h0100);
    do_read(3'h5, 1'b0);
    // second register write pulses once and leaves the burst settings alone
    i_sbc_ctrl_model.issue(3'b000, 3'h1, 16'h0000);
    @(posedge ref_clk_in);
    chk("mr1 pulse", 16'h0001, {15'h0, mr1});
    chk("config kept", {3'h0, cfg[12:9], 1'b0, cfg[7:0]}, {3'h0, bco});
    // every noted beat must have been seen
    chk("beats left", 16'h0000, 16'(exp_q.size()));
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    fails++;
    wrap_up();
  end
endmodule
